// [design/gss_map.vh]
// Purpose: Constants for the global status summary block.
// Assumes: One 100 MHz core clock; thermal status arrives as an input, status register 1 is latched inside from events.
// Notes: Bit positions, reset values and filter timing live here.
// Behaviour
// [RL1] Error flag set while watchdog failure counter bits 7:4 are nonzero.
// [RL2] Byte order: error, comm, reset_n, stage2, stage1, main fail, supply, failsafe.
// [RL3] Power-on reads 80h; slow supply ramp with undervoltage reads 82h.
// [RL4] Wrong clock count or standby parity failure flags communication error.
// [RL5] Watchdog failure or stuck data input sets fail-safe bit.
// [RL6] Stage two thermal bit holds until read-and-clear of thermal status.
// [RL7] Reset indicator returns inactive only on clear command to thermal status.
// [RL8] Supply fail is diagnostic; cleared by read-clear or recovery when unlocked.
// [RL9] Fail-safe cleared by watchdog trigger or clearing underlying status.
// [RL10] Undervoltage filtered 64 us after power-on reset.
// [RL11] Error flag ORs global bits 6-0, status1 10-0, status3 15,11,7-2.
// [RL12] Failures without own global bit still raise the error flag.
// [RL13] Open-load, overcurrent, regulator events latch until read-and-clear.
// [RL14] Global byte sampled at chip select fall, shifted first in frame.
`ifndef GSS_MAP_VH
`define GSS_MAP_VH
`define GSS_BIT_ERR 7
`define GSS_BIT_COMM 6
`define GSS_BIT_RSTN 5
`define GSS_BIT_TS2 4
`define GSS_BIT_TS1 3
`define GSS_BIT_MAIN 2
`define GSS_BIT_SUP 1
`define GSS_BIT_FS 0
`define GSS_RESET_BYTE 8'h80
`define GSS_NORMAL_BYTE 8'h20
`define GSS_UV_FILTER_NS 64000
`define GSS_CLK_PERIOD_NS 10
`define GSS_UV_FILTER_CYC ((`GSS_UV_FILTER_NS + `GSS_CLK_PERIOD_NS - 1) / `GSS_CLK_PERIOD_NS)
`define GSS_SR1_LATCH_MASK 16'hFB7F
`define GSS_SR1_UV_BIT 10
`define GSS_SR1_OV_BIT 7
`define GSS_SR1_TOP_BIT 15
`endif

// [design/gss_global_status.v]
// Purpose: Global status byte and error flag of a power management device.
// Assumes: Event inputs are one-cycle pulses or levels synchronous to the clock.
// Notes: Serial frame decoding is outside; this block gets decoded strobes.
`timescale 1ns/1ps
`include "gss_map.vh"
module gss_global_status #(
	parameter UV_FILTER_CYC = `GSS_UV_FILTER_CYC
) (
	// Clock, reset, enable.
	input wire core_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	// Frame side strobes.
	input wire chip_select_low_active_in,
	input wire frame_len_err_in,
	input wire parity_err_in,
	input wire serial_data_input_stuck_in,
	input wire rd_clr_sr1_in,
	input wire rd_clr_sr3_in,
	input wire clear_command_sr3_in,
	input wire wd_trigger_ok_in,
	// Condition inputs.
	input wire supply_undervoltage_in,
	input wire supply_overvoltage_in,
	input wire lockout_en_in,
	input wire thermal_stage_one_in,
	input wire thermal_stage_two_in,
	input wire main_reg_fail_in,
	input wire watchdog_failure_counter_event_in,
	input wire [14:0] sr1_events_in,
	input wire [15:0] thermal_watchdog_status_in,
	input wire other_fail_in,
	// Results.
	output reg [7:0] global_status_byte_out,
	output reg [7:0] frame_status_out,
	output reg [15:0] diag_outputs_supply_out
);
	// Last count before the undervoltage filter opens.
	localparam integer UV_LAST_I = UV_FILTER_CYC - 1;
	// The filter counter is 17 bits wide; the limit is cut to match.
	localparam [16:0] UV_LAST = UV_LAST_I[16:0];
	// Status bits that latch plain event inputs; supply bits come apart.
	localparam [15:0] LATCH_MASK = `GSS_SR1_LATCH_MASK;

	// Global byte state and its next value.
	reg [7:0] gsb_q;
	reg [7:0] gsb_d;

	// Snapshot of the byte taken for the next frame.
	reg [7:0] frame_d;

	// Undervoltage filter after reset.
	reg [16:0] uv_cnt_q;
	reg [16:0] uv_cnt_d;
	reg uv_armed_q;
	reg uv_armed_d;

	// Remembers that fail-safe came from a watchdog failure.
	reg wd_fs_q;
	reg wd_fs_d;

	// Previous select level, for the start-of-frame edge.
	reg cs_q;

	// Status register 1 image, one flip-flop per bit in the loop below.
	wire [15:0] sr1_q;
	wire [15:0] sr1_d;

	// Decoded conditions.
	wire sel_rise;
	wire uv_seen;
	wire sup_bad;
	wire wd_cnt_nz;
	wire sr3_err;

	// Undervoltage is ignored until the filter has run out.
	assign uv_seen = supply_undervoltage_in & uv_armed_q; // [RL10]
	assign sup_bad = uv_seen | supply_overvoltage_in;

	// A frame starts when select goes active.
	assign sel_rise = chip_select_low_active_in & ~cs_q;

	// Any nonzero watchdog failure count is an error on its own.
	assign wd_cnt_nz = thermal_watchdog_status_in[7:4] != 4'h0; // [RL1]

	// Thermal and watchdog status bits that feed the error flag.
	assign sr3_err = thermal_watchdog_status_in[15]
		| thermal_watchdog_status_in[11]
		| (|thermal_watchdog_status_in[7:2]); // [RL11]

	// Filter counter steps once per enabled cycle until it arms.
	always @* begin
		uv_cnt_d = uv_cnt_q;
		uv_armed_d = uv_armed_q;
		if (!uv_armed_q) begin
			if (uv_cnt_q >= UV_LAST)
				uv_armed_d = 1'b1; // [RL10]
			else
				uv_cnt_d = uv_cnt_q + 17'h00001;
		end
	end

	// Watchdog cause flag: a failure in the same cycle as a trigger wins.
	always @* begin
		wd_fs_d = wd_fs_q;
		if (wd_trigger_ok_in)
			wd_fs_d = 1'b0;
		if (watchdog_failure_counter_event_in)
			wd_fs_d = 1'b1;
	end

	// Snapshot at select rise keeps the first byte stable in-frame.
	always @* begin
		frame_d = frame_status_out;
		if (sel_rise)
			frame_d = gsb_q; // [RL14]
	end

	// One latch per status bit; a set beats a read-and-clear.
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_sr1
			reg bit_q;
			wire ev;
			wire auto_clr;
			if (i == `GSS_SR1_UV_BIT) begin : g_uv
				// Follows the filtered supply when lockout is off.
				assign ev = uv_seen;
				assign auto_clr = ~lockout_en_in & ~uv_seen; // [RL8]
			end else if (i == `GSS_SR1_OV_BIT) begin : g_ov
				assign ev = supply_overvoltage_in;
				assign auto_clr = ~lockout_en_in & ~supply_overvoltage_in;
			end else if (i == `GSS_SR1_TOP_BIT) begin : g_top
				// No event input reaches the top bit; it stays low.
				assign ev = 1'b0;
				assign auto_clr = 1'b0;
			end else begin : g_ev
				assign ev = sr1_events_in[i] & LATCH_MASK[i]; // [RL13]
				assign auto_clr = 1'b0;
			end
			assign sr1_d[i] = ev | (bit_q & ~rd_clr_sr1_in & ~auto_clr);
			assign sr1_q[i] = bit_q;
			// Enable low holds the bit like every other flip-flop.
			always @(posedge core_clk_in or posedge rst_in) begin
				if (rst_in)
					bit_q <= 1'b0;
				else if (clk_en_in)
					bit_q <= sr1_d[i]; // [RL13]
			end
		end
	endgenerate

	// Next state of the global byte: sets win over clears in one cycle.
	always @* begin
		gsb_d = gsb_q;
		// Communication error is dropped when the next frame begins.
		if (sel_rise)
			gsb_d[`GSS_BIT_COMM] = 1'b0;
		if (clear_command_sr3_in)
			gsb_d[`GSS_BIT_RSTN] = 1'b1; // [RL7]
		if (rd_clr_sr3_in) begin
			gsb_d[`GSS_BIT_TS2] = 1'b0; // [RL6]
			gsb_d[`GSS_BIT_TS1] = 1'b0;
			gsb_d[`GSS_BIT_MAIN] = 1'b0;
		end
		if (rd_clr_sr1_in || (!lockout_en_in && !sup_bad))
			gsb_d[`GSS_BIT_SUP] = 1'b0; // [RL8]
		if ((wd_trigger_ok_in && wd_fs_q) || rd_clr_sr3_in)
			gsb_d[`GSS_BIT_FS] = 1'b0; // [RL9]
		if (frame_len_err_in || parity_err_in) begin
			gsb_d[`GSS_BIT_COMM] = 1'b1; // [RL4]
			gsb_d[`GSS_BIT_RSTN] = 1'b0;
		end
		if (thermal_stage_two_in) begin
			gsb_d[`GSS_BIT_TS2] = 1'b1;
			gsb_d[`GSS_BIT_FS] = 1'b1;
		end
		if (thermal_stage_one_in || thermal_stage_two_in)
			gsb_d[`GSS_BIT_TS1] = 1'b1;
		if (main_reg_fail_in)
			gsb_d[`GSS_BIT_MAIN] = 1'b1;
		if (sup_bad)
			gsb_d[`GSS_BIT_SUP] = 1'b1; // [RL3]
		if (watchdog_failure_counter_event_in || serial_data_input_stuck_in)
			gsb_d[`GSS_BIT_FS] = 1'b1; // [RL5]
		// The reset indicator is active low, so its low level counts.
		// The flag is an OR of the settled bits, so it clears itself.
		gsb_d[`GSS_BIT_ERR] = gsb_d[`GSS_BIT_COMM]
			| ~gsb_d[`GSS_BIT_RSTN]
			| (|gsb_d[4:0])
			| (|sr1_d[10:0])
			| sr3_err
			| wd_cnt_nz // [RL1]
			| other_fail_in; // [RL11] [RL12] [RL2]
	end

	// Reset value 80h: error high, reset indicator active low.
	// The reset branch loads constants only.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gsb_q <= `GSS_RESET_BYTE; // [RL3]
			uv_cnt_q <= 17'h00000;
			uv_armed_q <= 1'b0;
			wd_fs_q <= 1'b0;
			cs_q <= 1'b0;
			global_status_byte_out <= `GSS_RESET_BYTE;
			frame_status_out <= `GSS_RESET_BYTE;
			diag_outputs_supply_out <= 16'h0000;
		end else if (clk_en_in) begin
			gsb_q <= gsb_d;
			uv_cnt_q <= uv_cnt_d;
			uv_armed_q <= uv_armed_d;
			wd_fs_q <= wd_fs_d;
			cs_q <= chip_select_low_active_in;
			// Outputs show the next state so they match the inner image.
			global_status_byte_out <= gsb_d;
			diag_outputs_supply_out <= sr1_d;
			frame_status_out <= frame_d;
		end
	end
endmodule

// [tb/gss_chk.sv]
// Purpose: Port checker for the global status block.
// Assumes: Checks pause while the clock enable is low.
// Notes: Bound to every instance.
`timescale 1ns/1ps
module gss_chk(
	// Watched ports.
	input wire core_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	input wire frame_len_err_in,
	input wire watchdog_failure_counter_event_in,
	input wire rd_clr_sr1_in,
	input wire rd_clr_sr3_in,
	input wire clear_command_sr3_in,
	input wire thermal_stage_two_in,
	input wire other_fail_in,
	input wire [15:0] thermal_watchdog_status_in,
	input wire [7:0] global_status_byte_out,
	input wire [15:0] diag_outputs_supply_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in || !clk_en_in);
	// Flags must set one cycle after their cause; sticky bits must outlive every cycle without their clear.
	a_wd_count_err: assert property (|thermal_watchdog_status_in[7:4] |=> global_status_byte_out[7]) else $error("count flag");
	a_comm_err_set: assert property (frame_len_err_in |=> global_status_byte_out[7:6] == 2'h3) else $error("comm");
	a_fail_safe_set: assert property (watchdog_failure_counter_event_in |=> global_status_byte_out[7] && global_status_byte_out[0]) else $error("fs");
	a_stage_two_set: assert property (thermal_stage_two_in |=> global_status_byte_out[4:3] == 2'h3) else $error("ts2");
	a_stage_two_hold: assert property (global_status_byte_out[4] && !rd_clr_sr3_in |=> global_status_byte_out[4]) else $error("ts2 hold");
	a_rst_ind_hold: assert property (!global_status_byte_out[5] && !clear_command_sr3_in |=> !global_status_byte_out[5]) else $error("rstn");
	a_other_fail: assert property (other_fail_in |=> global_status_byte_out[7]) else $error("other");
	a_event_latch: assert property (diag_outputs_supply_out[0] && !rd_clr_sr1_in |=> diag_outputs_supply_out[0]) else $error("latch");
endmodule
bind gss_global_status gss_chk u_gss_chk(.*);

// [tb/gss_mcu.sv]
// Purpose: Serial master model issuing decoded frame strobes.
// Assumes: One strobe at a time.
// Notes: Bits: sel,len,par,stuck,rc1,rc3,clr,wdok.
`timescale 1ns/1ps
module gss_mcu(
	// Clock and strobes.
	input wire clk_in,
	output reg [7:0] strobe_out
);
	initial strobe_out = 8'h00;
	// Held one full cycle so exactly one edge takes it; clear is sent here.
	task send(input [7:0] s);
		begin
			@(posedge clk_in) #1 strobe_out = s;
			@(posedge clk_in) #1 strobe_out = 8'h00;
		end
	endtask
endmodule

// [tb/gss_global_status_tb_top.sv]
// Purpose: Self-checking bench for the global status block.
// Assumes: Filter shortened to 8 cycles.
// Notes: Inputs move 1 ns after the edge.
`timescale 1ns/1ps
module gss_global_status_tb_top;
	reg clk = 0, rst = 1, uv = 1, ts2 = 0, wdf = 0, oth = 0;
	reg en = 1, ov = 0, lock = 0, ts1 = 0, mrf = 0;
	reg [14:0] ev = 15'h0000;
	reg [15:0] tws = 16'h0000;
	wire [7:0] st, g, f;
	wire [15:0] d;
	integer num_errors = 0, checks_done = 0;
	gss_mcu u_gss_mcu(.clk_in(clk), .strobe_out(st));
	gss_global_status #(.UV_FILTER_CYC(8)) u_gss_global_status(
		.core_clk_in(clk), .rst_in(rst), .clk_en_in(en),
		.chip_select_low_active_in(st[0]), .frame_len_err_in(st[1]),
		.parity_err_in(st[2]), .serial_data_input_stuck_in(st[3]),
		.rd_clr_sr1_in(st[4]), .rd_clr_sr3_in(st[5]),
		.clear_command_sr3_in(st[6]), .wd_trigger_ok_in(st[7]),
		.supply_undervoltage_in(uv), .supply_overvoltage_in(ov),
		.lockout_en_in(lock), .thermal_stage_one_in(ts1),
		.thermal_stage_two_in(ts2), .main_reg_fail_in(mrf),
		.watchdog_failure_counter_event_in(wdf), .sr1_events_in(ev),
		.thermal_watchdog_status_in(tws), .other_fail_in(oth),
		.global_status_byte_out(g), .frame_status_out(f),
		.diag_outputs_supply_out(d));
	task chk(input string n, input [15:0] s, input [15:0] e);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED %0s exp %h seen %h", n, e, s);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task final_report;
		begin
			$display("checks %0d errors %0d", checks_done, num_errors);
			if (num_errors == 0 && checks_done > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task t_power;
		begin
			cyc(2);
			chk("g", g, 8'h80);
			cyc(10);
			chk("g", g, 8'h82);
			uv = 0;
			cyc(2);
			chk("g", g, 8'h80);
		end
	endtask
	task t_comm;
		begin
			u_gss_mcu.send(8'h02);
			chk("g", g, 8'hC0);
			u_gss_mcu.send(8'h04);
			chk("g", g, 8'hC0);
			u_gss_mcu.send(8'h40);
			u_gss_mcu.send(8'h01);
			chk("g", g, 8'h20);
			chk("f", f, 8'hE0);
		end
	endtask
	task t_fail;
		begin
			wdf = 1;
			cyc(1);
			wdf = 0;
			chk("g", g, 8'hA1);
			u_gss_mcu.send(8'h80);
			chk("g", g, 8'h20);
			u_gss_mcu.send(8'h08);
			chk("g", g, 8'hA1);
			u_gss_mcu.send(8'h20);
			chk("g", g, 8'h20);
			tws = 16'h0010;
			cyc(1);
			chk("g", g, 8'hA0);
			tws = 16'h0000;
			ts2 = 1;
			cyc(1);
			ts2 = 0;
			cyc(4);
			chk("g", g, 8'hB9);
			u_gss_mcu.send(8'h20);
			chk("g", g, 8'h20);
		end
	endtask
	task t_misc;
		begin
			oth = 1;
			cyc(1);
			chk("g", g, 8'hA0);
			oth = 0;
			ev = 15'h0001;
			cyc(1);
			ev = 15'h0000;
			cyc(3);
			chk("d", d, 16'h0001);
			chk("g", g, 8'hA0);
			u_gss_mcu.send(8'h10);
			chk("d", d, 16'h0000);
		end
	endtask
	task t_more;
		begin
			chk("g", g, 8'h20);
			lock = 1;
			uv = 1;
			ov = 1;
			cyc(1);
			uv = 0;
			ov = 0;
			cyc(2);
			chk("g", g, 8'hA2);
			chk("d", d, 16'h0480);
			u_gss_mcu.send(8'h10);
			chk("g", g, 8'h20);
			lock = 0;
			ts1 = 1;
			cyc(1);
			ts1 = 0;
			chk("g", g, 8'hA8);
			u_gss_mcu.send(8'h20);
			chk("g", g, 8'h20);
			mrf = 1;
			cyc(1);
			mrf = 0;
			chk("g", g, 8'hA4);
			u_gss_mcu.send(8'h20);
			chk("g", g, 8'h20);
			en = 0;
			oth = 1;
			cyc(2);
			chk("g", g, 8'h20);
			oth = 0;
			en = 1;
		end
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		cyc(20);
		rst = 0;
		t_power;
		t_comm;
		t_fail;
		t_misc;
		t_more;
		final_report;
	end
	// Tests need about 80 cycles.
	initial begin
		#50000;
		num_errors = num_errors + 1;
		final_report;
	end
endmodule
